// ### core/eee_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts of the low-power page
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one register per aligned word or halfword
// Notes:   Definitions only
`ifndef EEE_CFG_SVH
`define EEE_CFG_SVH

`define EEE_NPORT          9
`define EEE_OFF_ENABLE     8'h00
`define EEE_OFF_ASSERT     8'h02
`define EEE_OFF_INDICATE   8'h04
`define EEE_OFF_IDLE       8'h06
`define EEE_OFF_PIPE       8'h0c
`define EEE_OFF_SLEEP_G    8'h10
`define EEE_OFF_SLEEP_F    8'h34
`define EEE_OFF_MINLP_G    8'h58
`define EEE_OFF_MINLP_F    8'h7c
`define EEE_OFF_WAKE_G     8'ha0
`define EEE_OFF_WAKE_F     8'hb2
`define EEE_OFF_GLB_TH     8'hc4
`define EEE_OFF_TXQ_TH     8'hc6
`define EEE_OFF_TXQ_LAST   8'hd0
`define EEE_OFF_IRQ_STAT   8'he0
`define EEE_OFF_IRQ_MASK   8'he4
`define EEE_OFF_SPEED      8'he8
`define EEE_STRIDE32       8'h04
`define EEE_STRIDE16       8'h02
`define EEE_RST_PIPE       32'h0000_0020
`define EEE_RST_SLEEP_G    32'h0000_0004
`define EEE_RST_SLEEP_F    32'h0000_0028
`define EEE_RST_MINLP_G    32'h0000_0032
`define EEE_RST_MINLP_F    32'h0000_01f4
`define EEE_RST_WAKE       16'h0011
`define EEE_RST_TH         16'h0000
`define EEE_RST_ENABLE     9'h000
`define EEE_CLK_HZ         25000000
`define EEE_US_NS          1000
`define EEE_CLK_NS         40
`define EEE_US_CYCLES      ((`EEE_US_NS + `EEE_CLK_NS - 1) / `EEE_CLK_NS)
`define EEE_IRQ_LPI_ON     0
`define EEE_IRQ_LPI_OFF    1
`define EEE_IRQ_RX_ON      2

`endif

// ### core/eee_pkg.sv
// Purpose: Types shared by the low-power page
// Assumes: Nothing
// Notes:   Gray-coded per-port transmit states
package eee_pkg;
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_DRAIN  = 2'b01,
    ST_LPI    = 2'b11,
    ST_WAKE   = 2'b10
  } lp_state_t;
  typedef logic [8:0] port_vec_t;
endpackage

// ### core/eee_port_control_status.sv
// Purpose: Per-port energy-efficient control and status page with LPI sequencing
// Assumes: One 25 MHz clock; MAC and PHY signals arrive from outside this clock domain
// Notes:   Avalon-MM slave with one wait state on every access
`include "eee_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Nine-bit enable, bit 8 management port
// - Read-only mirror of transmit low-power requests
// - Idle symbols start only after packet ends
// - Read-only mirror of receive indicate outputs
// - Indicate held while PHY sends low-power idle
// - Enable and three status registers at page start
// - Pipeline delay load value at 0Ch
// - Sleep timers, gigabit and fast blocks
// - Minimum low-power timers, gigabit and fast
// - Sixteen-bit wake timers, two blocks
// - Global and queue congestion thresholds
// - Minimum low-power and wake timers count microseconds
// - Pipeline delay counts clocks, reset 20h
module eee_port_control_status #(
  parameter int NPORT = `EEE_NPORT
) (
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  input  wire logic [7:0]        i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output var  logic [31:0]       o_avs_readdata,
  output var  logic              o_avs_waitrequest,
  input  wire eee_pkg::port_vec_t i_tx_low_power_request,
  input  wire eee_pkg::port_vec_t i_tx_busy,
  input  wire eee_pkg::port_vec_t i_rx_phy_lpi,
  input  wire eee_pkg::port_vec_t i_rx_phy_idle,
  output var  eee_pkg::port_vec_t o_tx_send_lpi,
  output var  eee_pkg::port_vec_t o_rx_low_power_seen,
  output var  logic              o_irq
);
  import eee_pkg::*;

  // Enable and view words are nine bits wide and every timer block holds one slot
  // per port, so any other count would misplace the management port
  if (NPORT != `EEE_NPORT) begin : g_bad_nport
    $error("Port count must be nine");
  end

  // A block running past the next base would alias two registers on one address
  if (`EEE_OFF_SLEEP_G + NPORT * `EEE_STRIDE32 > `EEE_OFF_SLEEP_F ||
      `EEE_OFF_SLEEP_F + NPORT * `EEE_STRIDE32 > `EEE_OFF_MINLP_G ||
      `EEE_OFF_MINLP_G + NPORT * `EEE_STRIDE32 > `EEE_OFF_MINLP_F ||
      `EEE_OFF_MINLP_F + NPORT * `EEE_STRIDE32 > `EEE_OFF_WAKE_G ||
      `EEE_OFF_WAKE_G + NPORT * `EEE_STRIDE16 > `EEE_OFF_WAKE_F ||
      `EEE_OFF_WAKE_F + NPORT * `EEE_STRIDE16 > `EEE_OFF_GLB_TH) begin : g_bad_map
    $error("Timer blocks overlap");
  end

  localparam int NQ = (`EEE_OFF_TXQ_LAST - `EEE_OFF_TXQ_TH) / `EEE_STRIDE16 + 1;

  // Input synchronisers; first stage read only by second stage
  port_vec_t req_s1, req_s2, busy_s1, busy_s2, rlpi_s1, rlpi_s2, ridle_s1, ridle_s2;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      req_s1   <= '0;
      req_s2   <= '0;
      busy_s1  <= '0;
      busy_s2  <= '0;
      rlpi_s1  <= '0;
      rlpi_s2  <= '0;
      ridle_s1 <= '0;
      ridle_s2 <= '0;
    end else begin
      req_s1   <= i_tx_low_power_request;
      req_s2   <= req_s1;
      busy_s1  <= i_tx_busy;
      busy_s2  <= busy_s1;
      rlpi_s1  <= i_rx_phy_lpi;
      rlpi_s2  <= rlpi_s1;
      ridle_s1 <= i_rx_phy_idle;
      ridle_s2 <= ridle_s1;
    end
  end

  // Registers
  port_vec_t   port_low_power_enable;
  port_vec_t   speed_fast;
  logic [31:0] pipeline_delay_timer;
  logic [31:0] sleep_timer_gigabit [NPORT];
  logic [31:0] sleep_timer_fast [NPORT];
  logic [31:0] min_low_power_timer_gigabit [NPORT];
  logic [31:0] min_low_power_timer_fast [NPORT];
  logic [15:0] wake_timer_gigabit [NPORT];
  logic [15:0] wake_timer_fast [NPORT];
  logic [15:0] global_congestion_threshold;
  logic [15:0] queue_congestion_threshold [NQ];
  logic [2:0]  irq_status;
  logic [2:0]  irq_mask;
  port_vec_t   tx_low_power_assert_view;
  port_vec_t   rx_low_power_indicate_view;

  // Index of a word inside a block of stride s, or -1 when outside
  function automatic int block_index(input logic [7:0] a, input logic [7:0] base,
                                     input logic [7:0] stride, input int n);
    int i;
    block_index = -1;
    for (i = 0; i < n; i++) begin
      if (a == 8'(base + 8'(i) * stride)) block_index = i;
    end
  endfunction

  // Merge writedata into a 32-bit value under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    int b;
    merge = old;
    for (b = 0; b < 4; b++) begin
      if (be[b]) merge[b*8 +: 8] = d[b*8 +: 8];
    end
  endfunction

  // Exact match of one register's offset; shared by the write and clear decoders
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    reg_hit = (a == off);
  endfunction

  // One wait state: the request is served on its second cycle
  logic served;
  logic access;
  assign access = (i_avs_read || i_avs_write) && !served;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      served            <= 1'b0;
      o_avs_waitrequest <= 1'b1;
    end else begin
      served            <= access;
      o_avs_waitrequest <= !access;
    end
  end

  logic wr_en, rd_en;
  assign wr_en = i_avs_write && access;
  assign rd_en = i_avs_read && access;

  int i_sg, i_sf, i_mg, i_mf, i_wg, i_wf, i_q;
  always_comb begin
    i_sg = block_index(i_avs_address, `EEE_OFF_SLEEP_G, `EEE_STRIDE32, NPORT);
    i_sf = block_index(i_avs_address, `EEE_OFF_SLEEP_F, `EEE_STRIDE32, NPORT);
    i_mg = block_index(i_avs_address, `EEE_OFF_MINLP_G, `EEE_STRIDE32, NPORT);
    i_mf = block_index(i_avs_address, `EEE_OFF_MINLP_F, `EEE_STRIDE32, NPORT);
    i_wg = block_index(i_avs_address, `EEE_OFF_WAKE_G, `EEE_STRIDE16, NPORT);
    i_wf = block_index(i_avs_address, `EEE_OFF_WAKE_F, `EEE_STRIDE16, NPORT);
    i_q  = block_index(i_avs_address, `EEE_OFF_TXQ_TH, `EEE_STRIDE16, NQ);
  end

  // Control words: enable, speed select and interrupt mask
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      port_low_power_enable <= `EEE_RST_ENABLE;
      speed_fast            <= '0;
      irq_mask              <= '0;
    end else if (wr_en) begin
      if (reg_hit(i_avs_address, `EEE_OFF_ENABLE))
        port_low_power_enable <= 9'(merge({23'h0, port_low_power_enable},
                                          i_avs_writedata, i_avs_byteenable));
      if (reg_hit(i_avs_address, `EEE_OFF_SPEED))
        speed_fast <= 9'(merge({23'h0, speed_fast}, i_avs_writedata, i_avs_byteenable));
      if (reg_hit(i_avs_address, `EEE_OFF_IRQ_MASK))
        irq_mask <= 3'(merge({29'h0, irq_mask}, i_avs_writedata, i_avs_byteenable));
    end
  end

  // Single words of the page: pipeline delay and global threshold
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pipeline_delay_timer        <= `EEE_RST_PIPE;
      global_congestion_threshold <= `EEE_RST_TH;
    end else if (wr_en) begin
      if (reg_hit(i_avs_address, `EEE_OFF_PIPE))
        pipeline_delay_timer <= merge(pipeline_delay_timer, i_avs_writedata,
                                      i_avs_byteenable);
      if (reg_hit(i_avs_address, `EEE_OFF_GLB_TH))
        global_congestion_threshold <= 16'(merge({16'h0, global_congestion_threshold},
                                                 i_avs_writedata, i_avs_byteenable));
    end
  end

  // Per-port timer blocks and queue thresholds
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int p = 0; p < NPORT; p++) begin
        sleep_timer_gigabit[p]         <= `EEE_RST_SLEEP_G;
        sleep_timer_fast[p]            <= `EEE_RST_SLEEP_F;
        min_low_power_timer_gigabit[p] <= `EEE_RST_MINLP_G;
        min_low_power_timer_fast[p]    <= `EEE_RST_MINLP_F;
        wake_timer_gigabit[p]          <= `EEE_RST_WAKE;
        wake_timer_fast[p]             <= `EEE_RST_WAKE;
      end
      for (int q = 0; q < NQ; q++) queue_congestion_threshold[q] <= `EEE_RST_TH;
    end else if (wr_en) begin
      if (i_sg >= 0) sleep_timer_gigabit[i_sg] <= merge(sleep_timer_gigabit[i_sg],
                                                        i_avs_writedata, i_avs_byteenable);
      if (i_sf >= 0) sleep_timer_fast[i_sf] <= merge(sleep_timer_fast[i_sf],
                                                     i_avs_writedata, i_avs_byteenable);
      if (i_mg >= 0) min_low_power_timer_gigabit[i_mg] <=
          merge(min_low_power_timer_gigabit[i_mg], i_avs_writedata, i_avs_byteenable);
      if (i_mf >= 0) min_low_power_timer_fast[i_mf] <=
          merge(min_low_power_timer_fast[i_mf], i_avs_writedata, i_avs_byteenable);
      if (i_wg >= 0) wake_timer_gigabit[i_wg] <= 16'(merge({16'h0, wake_timer_gigabit[i_wg]},
                                                i_avs_writedata, i_avs_byteenable));
      if (i_wf >= 0) wake_timer_fast[i_wf] <= 16'(merge({16'h0, wake_timer_fast[i_wf]},
                                             i_avs_writedata, i_avs_byteenable));
      if (i_q >= 0) queue_congestion_threshold[i_q] <=
          16'(merge({16'h0, queue_congestion_threshold[i_q]},
                    i_avs_writedata, i_avs_byteenable));
    end
  end

  // Microsecond tick shared by all ports
  localparam int US_CYCLES = `EEE_US_CYCLES;
  logic [$clog2(US_CYCLES+1)-1:0] us_count;
  logic                           us_tick;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      us_count <= '0;
      us_tick  <= 1'b0;
    end else begin
      us_tick  <= (us_count == $bits(us_count)'(US_CYCLES - 1));
      us_count <= (us_count == $bits(us_count)'(US_CYCLES - 1)) ? '0 : us_count + 1'b1;
    end
  end

  // Per-port transmit sequencer
  port_vec_t lpi_on_ev, lpi_off_ev;
  generate
    for (genvar p = 0; p < NPORT; p++) begin : g_port
      lp_state_t   state;
      logic [31:0] count;
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          state            <= ST_ACTIVE;
          count            <= '0;
          o_tx_send_lpi[p] <= 1'b0;
          lpi_on_ev[p]     <= 1'b0;
          lpi_off_ev[p]    <= 1'b0;
        end else begin
          lpi_on_ev[p]  <= 1'b0;
          lpi_off_ev[p] <= 1'b0;
          if (!port_low_power_enable[p]) begin
            state            <= ST_ACTIVE;
            o_tx_send_lpi[p] <= 1'b0;
            lpi_off_ev[p]    <= o_tx_send_lpi[p];
          end else begin
            case (state)
              ST_ACTIVE: begin
                if (req_s2[p]) begin
                  state <= ST_DRAIN;
                  count <= pipeline_delay_timer;
                end
              end
              ST_DRAIN: begin
                if (!req_s2[p]) state <= ST_ACTIVE;
                else if (count != '0) count <= count - 1'b1;
                else if (!busy_s2[p]) begin
                  state            <= ST_LPI;
                  o_tx_send_lpi[p] <= 1'b1;
                  lpi_on_ev[p]     <= 1'b1;
                  count <= speed_fast[p] ? min_low_power_timer_fast[p]
                                         : min_low_power_timer_gigabit[p];
                end
              end
              ST_LPI: begin
                if (us_tick && count != '0) count <= count - 1'b1;
                if (!req_s2[p] && count == '0) begin
                  state            <= ST_WAKE;
                  o_tx_send_lpi[p] <= 1'b0;
                  lpi_off_ev[p]    <= 1'b1;
                  count <= {16'h0, speed_fast[p] ? wake_timer_fast[p] : wake_timer_gigabit[p]};
                end
              end
              ST_WAKE: begin
                if (us_tick && count != '0) count <= count - 1'b1;
                if (count == '0) state <= ST_ACTIVE;
              end
              default: state <= ST_ACTIVE;
            endcase
          end
        end
      end
    end
  endgenerate

  // Status views, one flop behind the synchronisers
  port_vec_t rx_idle_symbol_status;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_low_power_assert_view   <= '0;
      rx_low_power_indicate_view <= '0;
      rx_idle_symbol_status      <= '0;
    end else begin
      tx_low_power_assert_view   <= req_s2;
      rx_low_power_indicate_view <= rlpi_s2;
      rx_idle_symbol_status      <= ridle_s2;
    end
  end

  // Receive indicate output; same stage as its view so the two never disagree
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rx_low_power_seen <= '0;
    end else begin
      o_rx_low_power_seen <= rlpi_s2;
    end
  end

  // Sticky events; an event in the clearing read's cycle survives
  logic [2:0] ev;
  logic       stat_rd;
  logic [2:0] next_irq_status;
  assign ev = {|(rlpi_s2 & ~rx_low_power_indicate_view), |lpi_off_ev, |lpi_on_ev};
  assign stat_rd = rd_en && reg_hit(i_avs_address, `EEE_OFF_IRQ_STAT);
  assign next_irq_status = (stat_rd ? 3'h0 : irq_status) | ev;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // Output follows the next status so it rises with the bit, not a cycle later
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(next_irq_status & irq_mask);
    end
  end

  // Read mux; unmapped words read as zero
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_avs_readdata <= '0;
    end else if (rd_en) begin
      o_avs_readdata <= '0;
      case (i_avs_address)
        `EEE_OFF_ENABLE:   o_avs_readdata <= {23'h0, port_low_power_enable};
        `EEE_OFF_ASSERT:   o_avs_readdata <= {23'h0, tx_low_power_assert_view};
        `EEE_OFF_INDICATE: o_avs_readdata <= {23'h0, rx_low_power_indicate_view};
        `EEE_OFF_IDLE:     o_avs_readdata <= {23'h0, rx_idle_symbol_status};
        `EEE_OFF_PIPE:     o_avs_readdata <= pipeline_delay_timer;
        `EEE_OFF_GLB_TH:   o_avs_readdata <= {16'h0, global_congestion_threshold};
        `EEE_OFF_IRQ_STAT: o_avs_readdata <= {29'h0, irq_status};
        `EEE_OFF_IRQ_MASK: o_avs_readdata <= {29'h0, irq_mask};
        `EEE_OFF_SPEED:    o_avs_readdata <= {23'h0, speed_fast};
        default: begin
          if (i_sg >= 0) o_avs_readdata <= sleep_timer_gigabit[i_sg];
          if (i_sf >= 0) o_avs_readdata <= sleep_timer_fast[i_sf];
          if (i_mg >= 0) o_avs_readdata <= min_low_power_timer_gigabit[i_mg];
          if (i_mf >= 0) o_avs_readdata <= min_low_power_timer_fast[i_mf];
          if (i_wg >= 0) o_avs_readdata <= {16'h0, wake_timer_gigabit[i_wg]};
          if (i_wf >= 0) o_avs_readdata <= {16'h0, wake_timer_fast[i_wf]};
          if (i_q >= 0)  o_avs_readdata <= {16'h0, queue_congestion_threshold[i_q]};
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### sim/eee_port_control_status_sva.sv
// Purpose: Bus handshake, view and sequencing checks on the low-power page
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Attached by bind below
`timescale 1ns/1ps
`default_nettype none
module eee_port_control_status_sva #(
  parameter int NPORT = 9
) (
  input wire logic               i_clk,
  input wire logic               i_reset_n,
  input wire logic [7:0]         i_avs_address,
  input wire logic               i_avs_read,
  input wire logic               i_avs_write,
  input wire logic [31:0]        i_avs_writedata,
  input wire logic [3:0]         i_avs_byteenable,
  input wire logic [31:0]        o_avs_readdata,
  input wire logic               o_avs_waitrequest,
  input wire eee_pkg::port_vec_t i_tx_low_power_request,
  input wire eee_pkg::port_vec_t i_tx_busy,
  input wire eee_pkg::port_vec_t i_rx_phy_lpi,
  input wire eee_pkg::port_vec_t i_rx_phy_idle,
  input wire eee_pkg::port_vec_t o_tx_send_lpi,
  input wire eee_pkg::port_vec_t o_rx_low_power_seen,
  input wire logic               o_irq
);
  import eee_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  chk_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("wait state low longer than one cycle");
  chk_answer_next: assert property ($rose(i_avs_read || i_avs_write) |=> !o_avs_waitrequest)
    else $error("access not answered in the next cycle");
  chk_no_spurious: assert property (!(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
    else $error("answer without a request");
  chk_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address == 8'h08
    |-> o_avs_readdata == 32'h0) else $error("unmapped read not zero");
  chk_enable_width: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address == 8'h00
    |-> o_avs_readdata[31:9] == 23'h0) else $error("enable upper bits not zero");
  chk_view_width: assert property (i_avs_read && !o_avs_waitrequest &&
    (i_avs_address == 8'h02 || i_avs_address == 8'h04) |-> o_avs_readdata[31:9] == 23'h0)
    else $error("status view upper bits not zero");
  chk_rx_follow: assert property (o_rx_low_power_seen == $past(i_rx_phy_lpi, 3))
    else $error("receive indicate does not follow phy idle state");
  chk_busy_holds: assert property ((o_tx_send_lpi & ~$past(o_tx_send_lpi) & i_tx_busy &
    $past(i_tx_busy) & $past(i_tx_busy, 2) & $past(i_tx_busy, 3)) == 9'h0)
    else $error("low-power symbols started during a packet");
  chk_req_needed: assert property ((o_tx_send_lpi & ~$past(o_tx_send_lpi) &
    ~$past(i_tx_low_power_request, 3)) == 9'h0) else $error("low power without request");
endmodule
bind eee_port_control_status eee_port_control_status_sva #(.NPORT(NPORT)) sva_inst (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_tx_low_power_request(i_tx_low_power_request),
  .i_tx_busy(i_tx_busy), .i_rx_phy_lpi(i_rx_phy_lpi), .i_rx_phy_idle(i_rx_phy_idle),
  .o_tx_send_lpi(o_tx_send_lpi), .o_rx_low_power_seen(o_rx_low_power_seen), .o_irq(o_irq));
`default_nettype wire

// ### sim/eee_mac_phy_model.sv
// Purpose: Behavioural MAC and PHY side of every port
// Assumes: Commands from the bench, applied one clock later
// Notes:   Phy sends normal idle whenever it is not sending low-power idle
`timescale 1ns/1ps
`default_nettype none
module eee_mac_phy_model (
  input  wire logic               i_clk,
  input  wire logic               i_reset_n,
  input  wire eee_pkg::port_vec_t i_request_cmd,
  input  wire eee_pkg::port_vec_t i_busy_cmd,
  input  wire eee_pkg::port_vec_t i_rx_lpi_cmd,
  output var  eee_pkg::port_vec_t o_tx_low_power_request,
  output var  eee_pkg::port_vec_t o_tx_busy,
  output var  eee_pkg::port_vec_t o_rx_phy_lpi,
  output var  eee_pkg::port_vec_t o_rx_phy_idle
);
  import eee_pkg::*;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_tx_low_power_request <= '0;
      o_tx_busy              <= '0;
      o_rx_phy_lpi           <= '0;
      o_rx_phy_idle          <= '0;
    end else begin
      o_tx_low_power_request <= i_request_cmd;
      o_tx_busy              <= i_busy_cmd;
      o_rx_phy_lpi           <= i_rx_lpi_cmd;
      o_rx_phy_idle          <= ~i_rx_lpi_cmd;
    end
  end
endmodule
`default_nettype wire

// ### sim/test_eee_port_control_status.sv
// Purpose: Register map, status views and low-power sequencing of the page
// Assumes: 25 MHz clock, minimum low-power time set to 2 us
// Notes:   Timers are shortened through the registers, not parameters
`timescale 1ns/1ps
`default_nettype none
module test_eee_port_control_status;
  import eee_pkg::*;
  logic        i_clk = 1'b0, i_reset_n = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [7:0]  i_avs_address = 8'h00;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, rd;
  logic [3:0]  i_avs_byteenable = 4'h0;
  logic [3:0]  lanes = 4'hf;
  logic        o_avs_waitrequest, o_irq;
  port_vec_t   req_cmd = '0, busy_cmd = '0, lpi_cmd = '0;
  port_vec_t   tx_req, tx_busy, phy_lpi, phy_idle, o_tx_send_lpi, o_rx_low_power_seen;
  int          n_fail = 0, check_count = 0, cycles = 0;
  logic [7:0]  ra [16] = '{8'h0c, 8'h10, 8'h30, 8'h34, 8'h54, 8'h58, 8'h78, 8'h7c, 8'h9c,
                           8'ha0, 8'hb0, 8'hb2, 8'hc2, 8'hc4, 8'hc6, 8'hd0};
  logic [31:0] rv [16] = '{32'h20, 32'h4, 32'h4, 32'h28, 32'h28, 32'h32, 32'h32, 32'h1f4,
                           32'h1f4, 32'h11, 32'h11, 32'h11, 32'h11, 32'h0, 32'h0, 32'h0};
  eee_port_control_status eee_port_control_status_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_tx_low_power_request(tx_req), .i_tx_busy(tx_busy), .i_rx_phy_lpi(phy_lpi),
    .i_rx_phy_idle(phy_idle), .o_tx_send_lpi(o_tx_send_lpi),
    .o_rx_low_power_seen(o_rx_low_power_seen), .o_irq(o_irq));
  eee_mac_phy_model eee_mac_phy_model_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_request_cmd(req_cmd), .i_busy_cmd(busy_cmd), .i_rx_lpi_cmd(lpi_cmd),
    .o_tx_low_power_request(tx_req), .o_tx_busy(tx_busy), .o_rx_phy_lpi(phy_lpi),
    .o_rx_phy_idle(phy_idle));
  initial begin
    forever #20 i_clk = ~i_clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Request held from one edge until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_byteenable <= lanes;
    if (wr) i_avs_write <= 1'b1;
    else i_avs_read <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    check("bus wait", 32'(n), 32'h2);
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask
  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'b1;
    for (int i = 0; i < 16; i++) rchk("reset value", ra[i], rv[i]);
    rchk("assert view reset", 8'h02, 32'h0);
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, ra[i], 32'h5a5a_0000 | ra[i]);
      rchk("readback", ra[i], i < 9 ? 32'h5a5a_0000 | ra[i] : 32'h0000_0000 | ra[i]);
    end
    lanes = 4'h1;
    bus(1'b1, 8'h0c, 32'hffff_ffff);
    lanes = 4'hf;
    rchk("byte lane", 8'h0c, 32'h5a5a_00ff);
    bus(1'b1, 8'h08, 32'hffff_ffff);
    rchk("unmapped", 8'h08, 32'h0);
    bus(1'b1, 8'h0c, 32'h8);
    for (int k = 0; k < 9; k++) bus(1'b1, 8'h58 + 8'(4 * k), 32'h2);
    for (int k = 0; k < 9; k++) bus(1'b1, 8'ha0 + 8'(2 * k), 32'h1);
    bus(1'b1, 8'he8, 32'h0);
    bus(1'b1, 8'h00, 32'hffff_ffff);
    rchk("enable", 8'h00, 32'h1ff);
    req_cmd <= 9'h1ff;
    busy_cmd <= 9'h001;
    repeat (60) @(posedge i_clk);
    check("lpi while busy", 32'(o_tx_send_lpi), 32'h1fe);
    busy_cmd <= 9'h000;
    repeat (30) @(posedge i_clk);
    check("lpi after packet", 32'(o_tx_send_lpi), 32'h1ff);
    bus(1'b1, 8'h02, 32'hffff);
    rchk("assert view", 8'h02, 32'h1ff);
    check("irq masked", 32'(o_irq), 32'h0);
    bus(1'b1, 8'he4, 32'h1);
    repeat (3) @(posedge i_clk);
    check("irq raised", 32'(o_irq), 32'h1);
    bus(1'b0, 8'he0, 32'h0);
    check("irq entered bit", 32'(rd[0]), 32'h1);
    repeat (3) @(posedge i_clk);
    check("irq cleared", 32'(o_irq), 32'h0);
    bus(1'b1, 8'h00, 32'h1f7);
    repeat (3) @(posedge i_clk);
    check("lpi port off", 32'(o_tx_send_lpi), 32'h1f7);
    bus(1'b1, 8'h00, 32'h1ff);
    repeat (14) @(posedge i_clk);
    check("lpi re-entered", 32'(o_tx_send_lpi), 32'h1ff);
    req_cmd <= 9'h000;
    repeat (10) @(posedge i_clk);
    check("lpi min hold", 32'(o_tx_send_lpi), 32'h008);
    repeat (100) @(posedge i_clk);
    check("lpi released", 32'(o_tx_send_lpi), 32'h0);
    lpi_cmd <= 9'h0aa;
    repeat (8) @(posedge i_clk);
    check("rx seen", 32'(o_rx_low_power_seen), 32'h0aa);
    rchk("indicate view", 8'h04, 32'h0aa);
    rchk("idle view", 8'h06, 32'h155);
    finish_test();
  end
endmodule
`default_nettype wire
